// ==== core/axis_status_regs.svh ====
// Constants of the per-axis status register bank: bit positions, codes, resets.
// Assumes inclusion by bare name from the design files and the test bench.
`ifndef AXIS_STATUS_REGS_SVH
`define AXIS_STATUS_REGS_SVH

// Register select codes on the read port
`define SEL_FACTOR 2'h0
`define SEL_ERROR 2'h1
`define SEL_PAGED 2'h2
`define SEL_MAIN 2'h3

// Command codes
`define CMD_STATUS_CLEAR 8'h79
`define CMD_PAGE0 8'h7a
`define CMD_PAGE1 8'h7b
`define CMD_NOP 8'h1f

// Factor bit positions
`define FAC_DRV_START 4
`define FAC_CONST_START 5
`define FAC_CONST_END 6
`define FAC_DRV_END 7
`define FAC_HOME_END 8
`define FAC_TIMER 9
`define FAC_SPLIT_END 11

// Error bit positions
`define ERR_SOFT_PLUS 0
`define ERR_SOFT_MINUS 1
`define ERR_HARD_PLUS 2
`define ERR_HARD_MINUS 3
`define ERR_ALARM 4
`define ERR_EMG 5
`define ERR_HOME 6
`define ERR_CONT 7
`define FIN_SYNC 8
`define FIN_PLUS 12
`define FIN_MINUS 13
`define FIN_ALARM 14
`define FIN_EMG 15

// Main status error summary bit for axis 0; axis 1 uses the next bit up
`define MAIN_ERR_POS 4

// Reset values
`define RST_FACTOR 16'h0000
`define RST_ERROR 16'h0000
`define RST_PAGE 1'b0
`define RST_AXIS 1'b0

`endif

// ==== core/axis_status_pkg.sv ====
// Types shared by the status bank: event and pin bundles of one axis.
// Needs nothing from the constants header; it includes no file.
package axis_status_pkg;

    // Events from the motion engines, one-cycle pulses
    typedef struct packed {
        logic [3:0] compare_match_flags;
        logic drive_start_flag;
        logic const_speed_start_flag;
        logic const_speed_end;
        logic drive_end;
        logic home_end;
        logic timer_expired;
        logic split_done_flag;
        logic [3:0] sync_action_flags;
    } axis_events_s;

    // Drive state and stop causes of one axis
    typedef struct packed {
        logic axis_driving_flag;
        logic dir_minus;
        logic interp_drive;
        logic soft_limit_en;
        logic soft_limit_plus;
        logic soft_limit_minus;
        logic hard_limit_en;
        logic alarm_en;
        logic home_step3_start;
        logic z_phase_active;
        logic continuous_interp_err;
        logic sync_stop;
    } axis_drive_s;

    // Motion status levels for page 1; the home search state goes to page 0
    typedef struct packed {
        logic [3:0] sync_active;
        logic accel_phase_flag;
        logic const_phase_flag;
        logic decel_phase_flag;
        logic jerk_rise_flag;
        logic jerk_flat_flag;
        logic jerk_fall_flag;
        logic timer_running;
        logic split_running;
        logic [5:0] home_search_state;
    } axis_motion_s;

    // Raw pins of one axis, low active where named so
    typedef struct packed {
        logic [2:0] ext_stop_pins;
        logic encoder_a_level;
        logic encoder_b_level;
        logic in_position_level;
        logic servo_alarm_pin;
        logic limit_plus_pin;
        logic limit_minus_pin;
    } axis_pins_s;

    typedef enum logic [1:0] {
        PAGE_INPUTS = 2'b01,
        PAGE_MOTION = 2'b10
    } page_e;

endpackage

// ==== core/pin_sync.sv ====
// Three-flop synchroniser with agreement filter for one pin bus.
// Assumes the pins are asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;
    logic [WIDTH-1:0] level_reg;
    logic [WIDTH-1:0] level_next;
    logic [WIDTH-1:0] agree;

    // A change counts only once the second and third stages agree
    assign agree = ~(stage2_reg ^ stage3_reg);
    assign level_next = (agree & stage3_reg) | (~agree & level_reg);
    assign pin_level = level_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
            stage3_reg <= '0;
            level_reg <= '0;
        end else begin
            stage1_reg <= pin_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg <= level_next;
        end
    end
endmodule
`default_nettype wire

// ==== core/axis_status_unit.sv ====
// One axis: interrupt factors, sticky error and finish bits, stop request.
// Assumes event pulses and drive levels on clock; pins already synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "axis_status_regs.svh"
module axis_status_unit
    import axis_status_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire axis_events_s events,
    input wire axis_drive_s drive,
    input wire axis_pins_s pins,
    input wire logic emergency_stop_n,
    input wire logic [15:0] interrupt_enable_reg,
    input wire logic [1:0] factor_clear_bytes,
    input wire logic status_clear,
    output logic [15:0] factor_q,
    output logic [15:0] error_q,
    output logic stop_request
);
    logic [15:0] factor_reg;
    logic [15:0] factor_next;
    logic [15:0] factor_set;
    logic [15:0] factor_keep;
    logic [15:0] error_reg;
    logic [15:0] error_next;
    logic [15:0] error_set;
    logic drv_reg;
    logic drive_begin;
    logic drv_plus;
    logic drv_minus;
    logic plus_limit;
    logic minus_limit;
    logic alarm_active;
    logic emg_active;

    // ****************************************
    // Interrupt factors
    // ****************************************
    assign factor_set[3:0] = events.compare_match_flags;  // see R3
    assign factor_set[`FAC_DRV_START] = events.drive_start_flag;  // see R4
    assign factor_set[`FAC_CONST_START] = events.const_speed_start_flag;
    assign factor_set[`FAC_CONST_END] = events.const_speed_end;
    assign factor_set[`FAC_DRV_END] = events.drive_end;
    assign factor_set[`FAC_HOME_END] = events.home_end;  // see R5
    assign factor_set[`FAC_TIMER] = events.timer_expired;
    assign factor_set[10] = 1'b0;
    assign factor_set[`FAC_SPLIT_END] = events.split_done_flag;
    assign factor_set[15:12] = events.sync_action_flags;  // see R6
    // Byte-wise clear keeps the untouched byte; set wins over clear
    assign factor_keep = factor_reg & ~{{8{factor_clear_bytes[1]}}, {8{factor_clear_bytes[0]}}};  // see R8
    assign factor_next = factor_keep | (factor_set & interrupt_enable_reg);  // see R2, see R25

    // ****************************************
    // Error and finishing causes
    // ****************************************
    assign drv_plus = drive.axis_driving_flag & ~drive.dir_minus;  // see R17
    assign drv_minus = drive.axis_driving_flag & drive.dir_minus;
    assign plus_limit = drive.hard_limit_en & ~pins.limit_plus_pin;
    assign minus_limit = drive.hard_limit_en & ~pins.limit_minus_pin;
    assign alarm_active = drive.alarm_en & ~pins.servo_alarm_pin;
    assign emg_active = ~emergency_stop_n;
    assign error_set[`ERR_SOFT_PLUS] = drv_plus & drive.soft_limit_en & drive.soft_limit_plus;  // see R13
    assign error_set[`ERR_SOFT_MINUS] = drv_minus & drive.soft_limit_en & drive.soft_limit_minus;
    assign error_set[`ERR_HARD_PLUS] = drv_plus & plus_limit;  // see R14, see R18
    assign error_set[`ERR_HARD_MINUS] = drv_minus & minus_limit;
    assign error_set[`ERR_ALARM] = drive.axis_driving_flag & alarm_active;
    assign error_set[`ERR_EMG] = drive.axis_driving_flag & emg_active;
    assign error_set[`ERR_HOME] = drive.home_step3_start & drive.z_phase_active;  // see R15
    assign error_set[`ERR_CONT] = drive.axis_driving_flag & drive.continuous_interp_err;  // see R16
    assign error_set[`FIN_SYNC] = drive.axis_driving_flag & drive.sync_stop;  // see R19
    assign error_set[11:9] = {3{drive.axis_driving_flag}} & ~pins.ext_stop_pins;
    assign error_set[`FIN_PLUS] = error_set[`ERR_HARD_PLUS];
    assign error_set[`FIN_MINUS] = error_set[`ERR_HARD_MINUS];
    assign error_set[`FIN_ALARM] = error_set[`ERR_ALARM];
    assign error_set[`FIN_EMG] = error_set[`ERR_EMG];
    // Start of a non-interpolation drive wipes old causes; new causes still land
    assign drive_begin = drive.axis_driving_flag & ~drv_reg & ~drive.interp_drive;
    assign error_next = ((status_clear | drive_begin) ? 16'h0000 : error_reg) | error_set;  // see R11
    assign stop_request = |error_set[7:0];

    assign factor_q = factor_reg;
    assign error_q = error_reg;

    always_ff @(posedge clock) begin
        if (rst) begin
            factor_reg <= `RST_FACTOR;
            error_reg <= `RST_ERROR;
            drv_reg <= 1'b0;
        end else begin
            factor_reg <= factor_next;
            error_reg <= error_next;
            drv_reg <= drive.axis_driving_flag;
        end
    end

    a_factor_kept: assert property (@(posedge clock) disable iff (rst)
        (events.drive_start_flag && interrupt_enable_reg[`FAC_DRV_START]) |=> factor_reg[`FAC_DRV_START])  // see R25
        else $error("Enabled drive start event lost");
    a_factor_gated: assert property (@(posedge clock) disable iff (rst)
        ($rose(factor_reg[`FAC_TIMER])) |-> $past(interrupt_enable_reg[`FAC_TIMER]))  // see R2
        else $error("Factor set without its enable");
    a_error_sticky: assert property (@(posedge clock) disable iff (rst)
        (error_reg[`ERR_HARD_MINUS] && !status_clear && !drive_begin) |=> error_reg[`ERR_HARD_MINUS])  // see R11
        else $error("Error bit dropped without a clear");
    a_stopped_quiet: assert property (@(posedge clock) disable iff (rst)
        (!drive.axis_driving_flag && !drive.home_step3_start && error_reg == 16'h0000) |=> error_reg == 16'h0000)  // see R17
        else $error("Error raised while axis stopped");
endmodule
`default_nettype wire

// ==== core/axis_status_bank.sv ====
// Two-axis status register bank: interrupt factors, error/finish and paged status.
// Assumes the host bus decoder gives a read strobe with a byte mask and command writes;
// event and drive signals come from engines on the same clock, pins are asynchronous.
//
// Functional notes
// R1: Each axis has its own status copies; reads use last command's axis.
// R2: Factor bits set and interrupt only when their enable bit is on.
// R3: Factor bits 3..0 set when compare condition becomes met.
// R4: Bits 4..7 set on drive start, constant start, constant end, drive end.
// R5: Bit 8 on home search end, 9 on timer, 11 on split end.
// R6: Bits 15..12 set when sync actions 3..0 activate.
// R7: Interrupt low while any factor set; reading clears read bits.
// R8: Byte reads clear only the byte read.
// R9: Serial host reads both factor bytes in one transfer.
// R10: Error bits 7..0 set on errors; any one sets summary bit.
// R11: Error/finish bits sticky; cleared by 79h or next drive start.
// R12: Host clears interpolation errors with 79h after drive stops.
// R13: Soft limits set bits 0 and 1 in their drive direction.
// R14: Hard limits, alarm, emergency set bits 2..5 and stop drive.
// R15: Z-phase active at home step 3 start sets bit 6.
// R16: Late continuous interpolation data sets bit 7 and stops drive.
// R17: No errors while stopped or for opposite-direction limits.
// R18: Same-direction drive under active limit is refused, error again.
// R19: Finish bits 15..8 record sync, stop pins, limits, alarm, emergency.
// R20: Paged register selected by 7Ah/7Bh; page 0 after reset.
// R21: Page 0 holds pin levels in bits 8..0, home state 14..9.
// R22: Page 1 holds sync, phase, S-curve, timer and split flags.
// R23: Bit 15 of paged register shows the page number.
// R24: Page 0 pins read raw level, unmoved by inversion options.
// R25: Factor event during a clearing read stays set.
`timescale 1ns/1ps
`default_nettype none
`include "axis_status_regs.svh"
module axis_status_bank
    import axis_status_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [1:0] cmd_axis,
    input wire logic rd_strobe,
    input wire logic [1:0] rd_select,
    input wire logic [1:0] rd_bytes,
    input wire logic [15:0] interrupt_enable_x,
    input wire logic [15:0] interrupt_enable_y,
    input wire axis_events_s events_x,
    input wire axis_events_s events_y,
    input wire axis_drive_s drive_x,
    input wire axis_drive_s drive_y,
    input wire axis_motion_s motion_x,
    input wire axis_motion_s motion_y,
    input wire axis_pins_s pins_x,
    input wire axis_pins_s pins_y,
    input wire logic emergency_stop_n,
    output logic [15:0] rd_data,
    output logic irq_out_n,
    output logic [1:0] stop_request,
    output logic [1:0] drive_refuse
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    axis_pins_s pins_x_s;
    axis_pins_s pins_y_s;
    logic emg_s;

    pin_sync #(.WIDTH($bits(axis_pins_s) * 2 + 1)) u_pins (
        .clock(clock),
        .rst(rst),
        .pin_async({pins_x, pins_y, emergency_stop_n}),
        .pin_level({pins_x_s, pins_y_s, emg_s})
    );

    // ****************************************
    // Command decode: axis pointer and page
    // ****************************************
    logic axis_reg;
    logic axis_next;
    page_e page_reg;
    page_e page_next;
    logic cmd_has_axis;
    logic clear_cmd;
    logic [1:0] status_clear;

    assign cmd_has_axis = cmd_write & (cmd_axis != 2'h0);
    // Both bits set selects X; status reads then come from X
    assign axis_next = cmd_has_axis ? ~cmd_axis[0] : axis_reg;  // see R1
    assign page_next = (cmd_write && cmd_code == `CMD_PAGE1) ? PAGE_MOTION :
                       (cmd_write && cmd_code == `CMD_PAGE0) ? PAGE_INPUTS : page_reg;  // see R20
    assign clear_cmd = cmd_write & (cmd_code == `CMD_STATUS_CLEAR);
    assign status_clear = {2{clear_cmd}} & cmd_axis;  // see R11

    always_ff @(posedge clock) begin
        if (rst) begin
            axis_reg <= `RST_AXIS;
            page_reg <= PAGE_INPUTS;
        end else begin
            axis_reg <= axis_next;
            page_reg <= page_next;
        end
    end

    // ****************************************
    // Per-axis units
    // ****************************************
    logic factor_read;
    logic [1:0] clear_x;
    logic [1:0] clear_y;
    logic [15:0] factor_x;
    logic [15:0] factor_y;
    logic [15:0] error_x;
    logic [15:0] error_y;

    // A read clears only the bytes that it actually fetched
    assign factor_read = rd_strobe & (rd_select == `SEL_FACTOR);  // see R7
    assign clear_x = (factor_read && !axis_reg) ? rd_bytes : 2'h0;  // see R8
    assign clear_y = (factor_read && axis_reg) ? rd_bytes : 2'h0;

    axis_status_unit u_axis_x (
        .clock(clock),
        .rst(rst),
        .events(events_x),
        .drive(drive_x),
        .pins(pins_x_s),
        .emergency_stop_n(emg_s),
        .interrupt_enable_reg(interrupt_enable_x),
        .factor_clear_bytes(clear_x),
        .status_clear(status_clear[0]),
        .factor_q(factor_x),
        .error_q(error_x),
        .stop_request(stop_request[0])
    );

    axis_status_unit u_axis_y (
        .clock(clock),
        .rst(rst),
        .events(events_y),
        .drive(drive_y),
        .pins(pins_y_s),
        .emergency_stop_n(emg_s),
        .interrupt_enable_reg(interrupt_enable_y),
        .factor_clear_bytes(clear_y),
        .status_clear(status_clear[1]),
        .factor_q(factor_y),
        .error_q(error_y),
        .stop_request(stop_request[1])
    );

    // ****************************************
    // Refusal of drives into an active limit
    // ****************************************
    // Limit pins are low active; the drive engine holds off while this is high
    assign drive_refuse[0] = drive_x.hard_limit_en &
        (drive_x.dir_minus ? ~pins_x_s.limit_minus_pin : ~pins_x_s.limit_plus_pin);  // see R18
    assign drive_refuse[1] = drive_y.hard_limit_en &
        (drive_y.dir_minus ? ~pins_y_s.limit_minus_pin : ~pins_y_s.limit_plus_pin);

    // ****************************************
    // Read data assembly
    // ****************************************
    logic [15:0] page0_x;
    logic [15:0] page0_y;
    logic [15:0] page1_x;
    logic [15:0] page1_y;
    logic [15:0] paged_sel;
    logic [15:0] main_status_reg;
    logic [15:0] rd_mux;
    logic [15:0] rd_data_reg;
    logic irq_reg;

    // Raw levels, so pin swap options never move these bits
    assign page0_x = {1'b0, motion_x.home_search_state, pins_x_s.limit_minus_pin, pins_x_s.limit_plus_pin,
        pins_x_s.servo_alarm_pin, pins_x_s.in_position_level, pins_x_s.encoder_b_level,
        pins_x_s.encoder_a_level, pins_x_s.ext_stop_pins};  // see R21, see R24
    assign page0_y = {1'b0, motion_y.home_search_state, pins_y_s.limit_minus_pin, pins_y_s.limit_plus_pin,
        pins_y_s.servo_alarm_pin, pins_y_s.in_position_level, pins_y_s.encoder_b_level,
        pins_y_s.encoder_a_level, pins_y_s.ext_stop_pins};
    assign page1_x = {1'b1, 3'h0, motion_x.split_running, motion_x.timer_running, motion_x.jerk_fall_flag,
        motion_x.jerk_flat_flag, motion_x.jerk_rise_flag, motion_x.decel_phase_flag,
        motion_x.const_phase_flag, motion_x.accel_phase_flag, motion_x.sync_active};  // see R22, see R23
    assign page1_y = {1'b1, 3'h0, motion_y.split_running, motion_y.timer_running, motion_y.jerk_fall_flag,
        motion_y.jerk_flat_flag, motion_y.jerk_rise_flag, motion_y.decel_phase_flag,
        motion_y.const_phase_flag, motion_y.accel_phase_flag, motion_y.sync_active};
    assign paged_sel = (page_reg == PAGE_MOTION) ? (axis_reg ? page1_y : page1_x) :
                       (axis_reg ? page0_y : page0_x);
    assign main_status_reg = {10'h000, |error_y[7:0], |error_x[7:0], 2'h0,
        drive_y.axis_driving_flag, drive_x.axis_driving_flag};  // see R10
    assign rd_mux = (rd_select == `SEL_FACTOR) ? (axis_reg ? factor_y : factor_x) :
                    (rd_select == `SEL_ERROR) ? (axis_reg ? error_y : error_x) :
                    (rd_select == `SEL_PAGED) ? paged_sel : main_status_reg;  // see R1

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data_reg <= 16'h0000;
            irq_reg <= 1'b0;
        end else begin
            if (rd_strobe) begin
                rd_data_reg <= rd_mux;
            end
            irq_reg <= (|factor_x) | (|factor_y);
        end
    end

    assign rd_data = rd_data_reg;
    assign irq_out_n = ~irq_reg;  // see R7

    // ****************************************
    // Checks
    // ****************************************
    sequence s_factor_read_x;
        factor_read && !axis_reg && rd_bytes == 2'h3 && events_x == '0;
    endsequence

    a_read_clears: assert property (@(posedge clock) disable iff (rst)
        s_factor_read_x |=> factor_x == 16'h0000)  // see R7
        else $error("Full factor read did not clear");
    a_irq_follows: assert property (@(posedge clock) disable iff (rst)
        (factor_x != 16'h0000) |=> !irq_out_n)  // see R7
        else $error("Interrupt not asserted with factor set");
    a_byte_clear: assert property (@(posedge clock) disable iff (rst)
        (factor_read && !axis_reg && rd_bytes == 2'h1) |=>
        ($past(factor_x[15:8]) & ~factor_x[15:8]) == 8'h00)  // see R8
        else $error("Low byte read touched high byte");
    a_page_reset: assert property (@(posedge clock)
        $fell(rst) |-> page_reg == PAGE_INPUTS)  // see R20
        else $error("Page not zero after reset");
    a_page_bit: assert property (@(posedge clock) disable iff (rst)
        (rd_strobe && rd_select == `SEL_PAGED) |=> rd_data[15] == $past(page_reg == PAGE_MOTION))  // see R23
        else $error("Page bit wrong");
    a_err_summary: assert property (@(posedge clock) disable iff (rst)
        (error_x[7:0] != 8'h00) |-> main_status_reg[`MAIN_ERR_POS])  // see R10
        else $error("Error summary missing");
endmodule
`default_nettype wire

// ==== sim/host_model.sv ====
// Host CPU model: writes commands and reads the status registers of the bank.
// Assumes the bank samples on the rising edge; this model drives on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clock,
    input wire logic [15:0] rd_data,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [1:0] cmd_axis,
    output logic rd_strobe,
    output logic [1:0] rd_select,
    output logic [1:0] rd_bytes
);
    initial begin
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_axis = 2'h0;
        rd_strobe = 1'b0;
        rd_select = 2'h0;
        rd_bytes = 2'h0;
    end

    task automatic command(input logic [7:0] code, input logic [1:0] axis);
        @(negedge clock);
        cmd_write = 1'b1;
        cmd_code = code;
        cmd_axis = axis;
        @(negedge clock);
        cmd_write = 1'b0;
    endtask

    // Data stands from the edge after the strobe
    task automatic read(input logic [1:0] sel, input logic [1:0] lanes, output logic [15:0] data);
        @(negedge clock);
        rd_strobe = 1'b1;
        rd_select = sel;
        rd_bytes = lanes;
        @(negedge clock);
        rd_strobe = 1'b0;
        @(negedge clock);
        data = rd_data;
    endtask
endmodule
`default_nettype wire

// ==== sim/axis_status_interrupt_regs_test.sv ====
// Self-checking bench of the two-axis status register bank.
// Assumes the bank and its constants header from core/; host model from sim/.
`timescale 1ns/1ps
`default_nettype none
`include "axis_status_regs.svh"
module axis_status_interrupt_regs_test
    import axis_status_pkg::*;
;
    typedef struct packed {logic [15:0] en; logic [14:0] ev; logic [15:0] exp;} frow_s;
    typedef struct packed {logic [7:0] code; logic [1:0] axis; logic [15:0] exp;} prow_s;
    logic clock, rst, cmd_write, rd_strobe, irq_out_n, emg_n;
    logic [7:0] cmd_code;
    logic [1:0] cmd_axis, rd_select, rd_bytes, stop_request, drive_refuse;
    logic [15:0] rd_data, ie_x, ie_y, d;
    axis_events_s ev_x, ev_y;
    axis_drive_s dr_x, dr_y;
    axis_motion_s mo_x, mo_y;
    axis_pins_s pi_x, pi_y;
    int mismatches = 0;
    int total_checks = 0;
    frow_s frows [11] = '{'{16'hffff, 15'h7800, 16'h000f}, '{16'hffff, 15'h0400, 16'h0010},
        '{16'hffff, 15'h0200, 16'h0020}, '{16'hffff, 15'h0100, 16'h0040}, '{16'hffff, 15'h0080, 16'h0080},
        '{16'hffff, 15'h0040, 16'h0100}, '{16'hffff, 15'h0020, 16'h0200}, '{16'hffff, 15'h0010, 16'h0800},
        '{16'hffff, 15'h000f, 16'hf000}, '{16'h0000, 15'h7fff, 16'h0000}, '{16'h00f0, 15'h7fff, 16'h00f0}};
    prow_s prows [5] = '{'{`CMD_NOP, 2'h1, 16'h56cf}, '{`CMD_PAGE1, 2'h1, 16'h84d5},
        '{`CMD_NOP, 2'h2, 16'h800a}, '{`CMD_PAGE0, 2'h2, 16'h29ff}, '{`CMD_NOP, 2'h3, 16'h56cf}};

    host_model host_u (.clock(clock), .rd_data(rd_data), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_axis(cmd_axis), .rd_strobe(rd_strobe), .rd_select(rd_select), .rd_bytes(rd_bytes));

    axis_status_bank dut_u (.clock(clock), .rst(rst), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_axis(cmd_axis), .rd_strobe(rd_strobe), .rd_select(rd_select), .rd_bytes(rd_bytes),
        .interrupt_enable_x(ie_x), .interrupt_enable_y(ie_y), .events_x(ev_x), .events_y(ev_y),
        .drive_x(dr_x), .drive_y(dr_y), .motion_x(mo_x), .motion_y(mo_y), .pins_x(pi_x), .pins_y(pi_y),
        .emergency_stop_n(emg_n), .rd_data(rd_data), .irq_out_n(irq_out_n), .stop_request(stop_request),
        .drive_refuse(drive_refuse));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Bound well above the test length
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        end_sim();
    end

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        rst = 1'b1;
        emg_n = 1'b1;
        {ie_x, ie_y, ev_x, ev_y, dr_x, dr_y} = '0;
        ie_y = 16'hffff;
        // Minus limit active on X, axis stopped
        pi_x = 9'h1e6;
        pi_y = 9'h1ff;
        mo_x = {4'h5, 8'hb2, 6'h2b};
        mo_y = {4'ha, 8'h00, 6'h14};
        repeat (12) @(negedge clock);
        rst = 1'b0;
        repeat (6) @(negedge clock);
        check("irq after reset", {15'h0, irq_out_n}, 16'h0001);
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("error after reset", d, 16'h0000);
        foreach (frows[i]) begin
            ie_x = frows[i].en;
            ev_x = frows[i].ev;
            @(negedge clock);
            ev_x = '0;
            repeat (2) @(negedge clock);
            check("irq level", {15'h0, irq_out_n}, {15'h0, frows[i].exp == 16'h0});
            host_u.read(`SEL_FACTOR, 2'h3, d);
            check("factor", d, frows[i].exp);
            @(negedge clock);
            check("irq released", {15'h0, irq_out_n}, 16'h0001);
            host_u.read(`SEL_FACTOR, 2'h3, d);
            check("factor cleared", d, 16'h0000);
        end
        ie_x = 16'hffff;
        ev_x = 15'h7fff;
        @(negedge clock);
        ev_x = '0;
        host_u.read(`SEL_FACTOR, 2'h1, d);
        check("low byte read", d, 16'hfbff);
        host_u.read(`SEL_FACTOR, 2'h2, d);
        check("high byte kept", d, 16'hfb00);
        host_u.read(`SEL_FACTOR, 2'h3, d);
        check("both bytes cleared", d, 16'h0000);
        fork
            host_u.read(`SEL_FACTOR, 2'h3, d);
            begin
                @(negedge clock);
                ev_x = 15'h0400;
                @(negedge clock);
                ev_x = '0;
            end
        join
        host_u.read(`SEL_FACTOR, 2'h3, d);
        check("event during clear", d, 16'h0010);
        foreach (prows[i]) begin
            host_u.command(prows[i].code, prows[i].axis);
            host_u.read(`SEL_PAGED, 2'h3, d);
            check("paged status", d, prows[i].exp);
        end
        dr_x.hard_limit_en = 1'b1;
        dr_x.dir_minus = 1'b1;
        @(negedge clock);
        check("refuse minus", {14'h0, drive_refuse}, 16'h0001);
        dr_x.dir_minus = 1'b0;
        @(negedge clock);
        check("refuse plus", {14'h0, drive_refuse}, 16'h0000);
        dr_x.axis_driving_flag = 1'b1;
        repeat (2) @(negedge clock);
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("opposite limit", d, 16'h0000);
        dr_x.dir_minus = 1'b1;
        repeat (2) @(negedge clock);
        check("stop request", {14'h0, stop_request}, 16'h0001);
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("minus limit error", d, 16'h2008);
        host_u.read(`SEL_MAIN, 2'h3, d);
        check("error summary", d, 16'h0011);
        dr_x.axis_driving_flag = 1'b0;
        pi_x = 9'h1e7;
        emg_n = 1'b0;
        repeat (6) @(negedge clock);
        emg_n = 1'b1;
        repeat (6) @(negedge clock);
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("sticky error", d, 16'h2008);
        host_u.command(`CMD_STATUS_CLEAR, 2'h1);
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("clear command", d, 16'h0000);
        host_u.read(`SEL_MAIN, 2'h3, d);
        check("summary cleared", d, 16'h0000);
        dr_x = '0;
        dr_x.axis_driving_flag = 1'b1;
        dr_x.soft_limit_en = 1'b1;
        dr_x.soft_limit_plus = 1'b1;
        repeat (2) @(negedge clock);
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("soft limit plus", d, 16'h0001);
        dr_x = '0;
        @(negedge clock);
        dr_x.axis_driving_flag = 1'b1;
        @(negedge clock);
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("drive start clears", d, 16'h0000);
        // Interpolation start keeps errors
        dr_x = 12'ha02;
        @(negedge clock);
        dr_x = 12'h200;
        @(negedge clock);
        dr_x[11] = 1'b1;
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("interp error kept", d, 16'h0080);
        dr_x = '0;
        host_u.command(`CMD_STATUS_CLEAR, 2'h1);
        host_u.read(`SEL_ERROR, 2'h3, d);
        check("interp cleared", d, 16'h0000);
        end_sim();
    end
endmodule
`default_nettype wire
